// ---- rf_converter_ctrl.v ----
// Control, counters and register slave of the R/F converter
//
// Design decision made here: the Avalon-MM slave port.
`include "rfc_consts.vh"
module rf_converter_ctrl #(
  parameter CW = 24
) (
  input wire ref_clk,
  input wire rst,
  input wire [17:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire osc_feedback,
  input wire external_count_input,
  output reg reference_osc_drive_r,
  output reg sensor_a_osc_drive_r,
  output reg sensor_b_osc_drive_r,
  output reg event_count_mode_out_r,
  output reg interrupt_request_r
);
  // Control bits and trigger state
  reg converter_enable_r;
  reg event_count_mode_r;
  reg continuous_osc_enable_r;
  reg [2:0] trigger_r;
  reg [2:0] trigger_nxt;

  // Counters and their next values
  reg [CW-1:0] measure_counter_r;
  reg [CW-1:0] measure_nxt;
  reg [CW-1:0] timebase_counter_r;
  reg [CW-1:0] timebase_nxt;

  // Interrupt mask, flags and flag events
  reg [4:0] int_mask_r;
  reg [4:0] flags_r;
  reg [4:0] flags_nxt;
  reg [4:0] flag_set;

  // Bus decode and read path
  reg [15:0] read_mux;
  wire wr_go;
  wire [15:0] reg_index;
  wire [15:0] wr16;

  // Count events, stop conditions and drive
  wire osc_rise;
  wire ext_rise;
  wire count_pulse;
  wire running_ref;
  wire running_sens;
  wire measure_wrap;
  wire timebase_wrap;
  wire timebase_zero;
  wire [2:0] drive_nxt;
  genvar ch;

  // Bus index is the byte address divided by four
  assign reg_index = avs_address[17:2];
  assign wr_go = avs_write & ~avs_waitrequest;
  assign wr16 = avs_writedata[15:0];

  // Byte-lane merge of a 16-bit register
  function [15:0] merge16;
    input [15:0] old_v;
    input [15:0] new_v;
    input [1:0] be;
    begin
      merge16[7:0] = be[0] ? new_v[7:0] : old_v[7:0];
      merge16[15:8] = be[1] ? new_v[15:8] : old_v[15:8];
    end
  endfunction

  // Address match for a given register index
  function hit;
    input [15:0] idx;
    input [15:0] target;
    begin
      hit = (idx == target);
    end
  endfunction

  // Oscillator feedback pin
  count_input_sync u_osc_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(osc_feedback),
    .rise_r(osc_rise)
  );

  // External event pin
  count_input_sync u_ext_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(external_count_input),
    .rise_r(ext_rise)
  );

  // Count source follows the mode bit
  assign count_pulse = event_count_mode_r ? ext_rise : osc_rise;
  assign running_ref = trigger_r[`BIT_REFERENCE];
  assign running_sens = trigger_r[`BIT_SENSOR_A] | trigger_r[`BIT_SENSOR_B];
  assign measure_wrap = count_pulse & (measure_counter_r == `COUNTER_MAX);
  assign timebase_wrap = running_ref & (timebase_counter_r == `COUNTER_MAX);
  assign timebase_zero = running_sens & (timebase_counter_r == 24'h000001);

  // Oscillator drive per channel, idle in event mode
  generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : g_drive
      assign drive_nxt[ch] = trigger_nxt[ch] & ~event_count_mode_r;
    end
  endgenerate

  // Counting, stop conditions and flag events
  always @* begin
    trigger_nxt = trigger_r;
    measure_nxt = measure_counter_r;
    timebase_nxt = timebase_counter_r;
    flag_set = 5'h00;
    // Count only while a trigger bit is set
    if (|trigger_r) begin
      // Measure counts input edges, timebase counts clocks
      if (count_pulse) begin
        measure_nxt = measure_counter_r + 24'h000001;
      end
      if (running_ref) begin
        timebase_nxt = timebase_counter_r + 24'h000001;
      end else begin
        timebase_nxt = timebase_counter_r - 24'h000001;
      end
      // Stop conditions only outside continuous mode
      if (!continuous_osc_enable_r) begin
        if (running_ref && measure_wrap) begin
          flag_set[`BIT_REFERENCE] = 1'b1;
          trigger_nxt = 3'h0;
        end else if (timebase_wrap) begin
          flag_set[`BIT_TIMEBASE_OVF] = 1'b1;
          trigger_nxt = 3'h0;
        end else if (running_sens && measure_wrap) begin
          flag_set[`BIT_MEASURE_OVF] = 1'b1;
          trigger_nxt = 3'h0;
        end else if (timebase_zero) begin
          flag_set[`BIT_SENSOR_A] = trigger_r[`BIT_SENSOR_A];
          flag_set[`BIT_SENSOR_B] = trigger_r[`BIT_SENSOR_B];
          trigger_nxt = 3'h0;
        end
      end
    end
    // Trigger writes act in every mode, only while enabled
    if (wr_go && avs_byteenable[0] && converter_enable_r &&
        hit(reg_index, `IDX_OSC_TRIGGER)) begin
      trigger_nxt = wr16[2:0];
    end
    // Counter writes win over counting
    if (wr_go && hit(reg_index, `IDX_MEASURE_LOW)) begin
      measure_nxt[15:0] = merge16(measure_counter_r[15:0], wr16,
                                  avs_byteenable[1:0]);
    end
    if (wr_go && avs_byteenable[0] && hit(reg_index, `IDX_MEASURE_HIGH)) begin
      measure_nxt[23:16] = wr16[7:0];
    end
    if (wr_go && hit(reg_index, `IDX_TIMEBASE_LOW)) begin
      timebase_nxt[15:0] = merge16(timebase_counter_r[15:0], wr16,
                                   avs_byteenable[1:0]);
    end
    if (wr_go && avs_byteenable[0] &&
        hit(reg_index, `IDX_TIMEBASE_HIGH)) begin
      timebase_nxt[23:16] = wr16[7:0];
    end
  end

  // Flags: write-one clears, a set in the same cycle wins
  always @* begin
    flags_nxt = flags_r;
    if (wr_go && avs_byteenable[0] && hit(reg_index, `IDX_INT_FLAG)) begin
      flags_nxt = flags_r & ~wr16[4:0];
    end
    flags_nxt = flags_nxt | flag_set;
  end

  // Read data mux, reserved bits as zero
  always @* begin
    read_mux = 16'h0000;
    case (reg_index)
      `IDX_CONVERTER_CONTROL: begin
        read_mux[`BIT_CONVERTER_ENABLE] = converter_enable_r;
        read_mux[`BIT_EVENT_COUNT_MODE] = event_count_mode_r;
        read_mux[`BIT_CONTINUOUS_OSC] = continuous_osc_enable_r;
      end
      `IDX_OSC_TRIGGER: begin
        read_mux[2:0] = trigger_r;
      end
      `IDX_MEASURE_LOW: begin
        read_mux = measure_counter_r[15:0];
      end
      `IDX_MEASURE_HIGH: begin
        read_mux[7:0] = measure_counter_r[23:16];
      end
      `IDX_TIMEBASE_LOW: begin
        read_mux = timebase_counter_r[15:0];
      end
      `IDX_TIMEBASE_HIGH: begin
        read_mux[7:0] = timebase_counter_r[23:16];
      end
      `IDX_INT_MASK: begin
        read_mux[4:0] = int_mask_r;
      end
      `IDX_INT_FLAG: begin
        read_mux[4:0] = flags_r;
      end
      default: begin
        read_mux = 16'h0000;
      end
    endcase
  end

  // Bus handshake: one wait cycle, then accept
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= {16'h0000, read_mux};
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // Control and mask registers
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      converter_enable_r <= 1'b0;
      event_count_mode_r <= 1'b0;
      continuous_osc_enable_r <= 1'b0;
      int_mask_r <= 5'h00;
    end else begin
      if (wr_go && avs_byteenable[0] &&
          hit(reg_index, `IDX_CONVERTER_CONTROL)) begin
        converter_enable_r <= wr16[`BIT_CONVERTER_ENABLE];
        event_count_mode_r <= wr16[`BIT_EVENT_COUNT_MODE];
        continuous_osc_enable_r <= wr16[`BIT_CONTINUOUS_OSC];
      end
      if (wr_go && avs_byteenable[0] && hit(reg_index, `IDX_INT_MASK)) begin
        int_mask_r <= wr16[4:0];
      end
    end
  end

  // Conversion state, counters, flags and outputs
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      trigger_r <= 3'h0;
      measure_counter_r <= `COUNTER_RESET;
      timebase_counter_r <= `COUNTER_RESET;
      flags_r <= `FLAGS_RESET;
      interrupt_request_r <= 1'b0;
      reference_osc_drive_r <= 1'b0;
      sensor_a_osc_drive_r <= 1'b0;
      sensor_b_osc_drive_r <= 1'b0;
      event_count_mode_out_r <= 1'b0;
    end else begin
      trigger_r <= trigger_nxt;
      measure_counter_r <= measure_nxt;
      timebase_counter_r <= timebase_nxt;
      flags_r <= flags_nxt;
      // Request follows the masked flags
      interrupt_request_r <= |(flags_nxt & int_mask_r);
      // Oscillator drive is idle in event mode
      reference_osc_drive_r <= drive_nxt[`BIT_REFERENCE];
      sensor_a_osc_drive_r <= drive_nxt[`BIT_SENSOR_A];
      sensor_b_osc_drive_r <= drive_nxt[`BIT_SENSOR_B];
      event_count_mode_out_r <= event_count_mode_r;
    end
  end
endmodule

// ---- rfc_consts.vh ----
// Register indices, field positions and reset values of the converter
`ifndef RF_CONVERTER_CONSTS_VH
`define RF_CONVERTER_CONSTS_VH
`define IDX_CONVERTER_CONTROL 16'h53A0
`define IDX_OSC_TRIGGER 16'h53A2
`define IDX_MEASURE_LOW 16'h53A4
`define IDX_MEASURE_HIGH 16'h53A6
`define IDX_TIMEBASE_LOW 16'h53A8
`define IDX_TIMEBASE_HIGH 16'h53AA
`define IDX_INT_MASK 16'h53AC
`define IDX_INT_FLAG 16'h53AE
`define BIT_CONVERTER_ENABLE 0
`define BIT_EVENT_COUNT_MODE 6
`define BIT_CONTINUOUS_OSC 7
`define BIT_REFERENCE 0
`define BIT_SENSOR_A 1
`define BIT_SENSOR_B 2
`define BIT_MEASURE_OVF 3
`define BIT_TIMEBASE_OVF 4
`define COUNTER_RESET 24'h000000
`define COUNTER_MAX 24'hFFFFFF
`define FLAGS_RESET 5'h00
`define SYNC_STAGES 2
`endif

// ---- count_input_sync.v ----
// Two-flop synchroniser with rising edge pulse for a count input pin
module count_input_sync (
  input wire ref_clk,
  input wire rst,
  input wire pin_in,
  output reg rise_r
);
  reg meta_r;
  reg sync_r;
  reg last_r;

  // First flop feeds only the second
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      last_r <= sync_r;
      rise_r <= sync_r & ~last_r;
    end
  end
endmodule

// ---- rfc_sva.sv ----
// Port-level checker for the converter control block
module rf_converter_sva (
  input wire ref_clk,
  input wire rst,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire reference_osc_drive_r,
  input wire sensor_a_osc_drive_r,
  input wire sensor_b_osc_drive_r,
  input wire event_count_mode_out_r,
  input wire interrupt_request_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wacc_r;
  wire req = avs_read | avs_write;
  wire [2:0] run = {sensor_b_osc_drive_r, sensor_a_osc_drive_r,
    reference_osc_drive_r};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Marks a write taken at the last edge
  always @(posedge ref_clk or posedge rst) begin
    if (rst) wacc_r <= 1'b0;
    else wacc_r <= avs_write & ~avs_waitrequest;
  end
  AST_WAIT_ONE: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("wait low longer than one cycle");
  AST_WAIT_ANS: assert property (
    req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  AST_IDLE_WAIT: assert property (!req |=> avs_waitrequest)
    else $error("answer without request");
  AST_RD_HIGH_ZERO: assert property (!avs_waitrequest |->
    avs_readdata[31:16] == 16'h0000) else $error("upper read bits set");
  AST_ONE_RUN: assert property ($onehot0(run))
    else $error("several oscillations running");
  AST_EVT_NO_DRIVE: assert property (event_count_mode_out_r |->
    run == 3'h0) else $error("oscillator driven in event mode");
  AST_START_BY_WRITE: assert property ($rose(|run) |->
    wacc_r || $past(wacc_r)) else $error("start without write");
  AST_MODE_BY_WRITE: assert property (
    $changed(event_count_mode_out_r) |-> wacc_r || $past(wacc_r))
    else $error("mode change without write");
  CV_IRQ: cover property ($rose(interrupt_request_r));
  CV_END: cover property ($fell(|run));
  CV_EVT: cover property ($rose(event_count_mode_out_r));
endmodule

// ---- cr_osc_model.sv ----
// Behavioural CR oscillator seen through its feedback pin
module cr_osc_model (
  input wire ref_clk,
  input wire run,
  output logic osc
);
  timeunit 1ns;
  timeprecision 1ps;
  initial osc = 1'b0;
  // Toggles while driven, rests low when stopped
  always @(posedge ref_clk) osc <= run ? ~osc : 1'b0;
endmodule

// ---- tb_top.sv ----
// Register-level testbench of the converter control block
`include "rfc_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst = 1, rd = 0, wr = 0, ext = 0;
  logic [17:0] adr = 0;
  logic [31:0] wd = 0;
  logic [3:0] be = 0;
  logic [15:0] q;
  wire [31:0] rdat;
  wire wq, osc, ra, sa, sb, evt, irq;
  int bad_count = 0, samples_checked = 0;
  initial forever #5 ref_clk = ~ref_clk;
  rf_converter_ctrl i_dut (.ref_clk(ref_clk), .rst(rst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wq), .osc_feedback(osc),
    .external_count_input(ext), .reference_osc_drive_r(ra),
    .sensor_a_osc_drive_r(sa), .sensor_b_osc_drive_r(sb),
    .event_count_mode_out_r(evt), .interrupt_request_r(irq));
  cr_osc_model i_osc (.ref_clk(ref_clk), .run(ra | sa | sb), .osc(osc));
  task test_done;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // One bus access, held until waitrequest is sampled low
  task acc(input bit w, input logic [15:0] i, input logic [15:0] d);
    int k;
    @(posedge ref_clk);
    adr <= {i, 2'b00};
    wd <= {16'h0000, d};
    be <= 4'h3;
    wr <= w;
    rd <= !w;
    for (k = 0; k < 20 && wq !== 1'b0; k++) @(posedge ref_clk);
    q = rdat[15:0];
    wr <= 1'b0;
    rd <= 1'b0;
    if (k == 20) begin
      bad_count++;
      test_done;
    end
  endtask
  task rdc(input string n, input logic [15:0] i, input logic [15:0] e);
    acc(0, i, 16'h0000);
    chk(n, q, e);
  endtask
  // Counter write, low half first
  task setc(input logic [15:0] i, input logic [23:0] v);
    acc(1, i, v[15:0]);
    acc(1, i + 16'h0002, {8'h00, v[23:16]});
  endtask
  // Polls the trigger until the oscillation has ended
  task wait_idle;
    int k;
    for (k = 0; k < 100; k++) begin
      acc(0, `IDX_OSC_TRIGGER, 16'h0000);
      if (q === 16'h0000) break;
    end
    chk("trigger end", q, 16'h0000);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++)
      rdc("reset", 16'h53A0 + 16'(2 * i), 16'h0000);
    acc(1, `IDX_OSC_TRIGGER, 16'h0001);
    rdc("trigger off", `IDX_OSC_TRIGGER, 16'h0000);
    acc(1, `IDX_CONVERTER_CONTROL, 16'hFFFF);
    rdc("control", `IDX_CONVERTER_CONTROL, 16'h00C1);
    acc(1, `IDX_INT_MASK, 16'hFFFF);
    rdc("mask", `IDX_INT_MASK, 16'h001F);
    acc(1, 16'h53B0, 16'hFFFF);
    rdc("unmapped", 16'h53B0, 16'h0000);
    for (int j = 0; j < 2; j++) begin
      setc(`IDX_MEASURE_LOW + 16'(4 * j), 24'hFEDCBA);
      rdc("count low", `IDX_MEASURE_LOW + 16'(4 * j),
          16'hDCBA);
      acc(1, `IDX_MEASURE_HIGH + 16'(4 * j), 16'hFFFF);
      rdc("count high", `IDX_MEASURE_HIGH + 16'(4 * j), 16'h00FF);
    end
    // Reference run ends on measure counter wrap
    acc(1, `IDX_CONVERTER_CONTROL, 16'h0001);
    acc(1, `IDX_INT_FLAG, 16'h001F);
    setc(`IDX_MEASURE_LOW, 24'hFFFFFC);
    setc(`IDX_TIMEBASE_LOW, 24'h000000);
    acc(1, `IDX_OSC_TRIGGER, 16'h0001);
    wait_idle;
    rdc("ref flag", `IDX_INT_FLAG, 16'h0001);
    chk("irq set", {15'h0000, irq}, 16'h0001);
    acc(1, `IDX_INT_FLAG, 16'h0000);
    rdc("flag kept", `IDX_INT_FLAG, 16'h0001);
    acc(1, `IDX_INT_FLAG, 16'h0001);
    rdc("flag cleared", `IDX_INT_FLAG, 16'h0000);
    chk("irq clear", {15'h0000, irq}, 16'h0000);
    // Sensor runs end when the timebase reaches zero; A masked
    for (int s = 1; s < 3; s++) begin
      acc(1, `IDX_INT_MASK, (s == 2) ? 16'h0004 : 16'h0000);
      acc(1, `IDX_INT_FLAG, 16'h001F);
      setc(`IDX_MEASURE_LOW, 24'h000000);
      setc(`IDX_TIMEBASE_LOW, 24'h000005);
      acc(1, `IDX_OSC_TRIGGER, 16'(1 << s));
      wait_idle;
      rdc("sensor flag", `IDX_INT_FLAG, 16'(1 << s));
      chk("irq mask", {15'h0000, irq}, 16'(s - 1));
    end
    // Continuous mode keeps running until written 0
    acc(1, `IDX_INT_FLAG, 16'h001F);
    acc(1, `IDX_CONVERTER_CONTROL, 16'h0081);
    setc(`IDX_TIMEBASE_LOW, 24'h000002);
    acc(1, `IDX_OSC_TRIGGER, 16'h0002);
    repeat (20) @(posedge ref_clk);
    chk("cont drive", {13'h0000, sb, sa, ra}, 16'h0002);
    rdc("cont run", `IDX_OSC_TRIGGER, 16'h0002);
    acc(1, `IDX_OSC_TRIGGER, 16'h0000);
    rdc("cont stop", `IDX_OSC_TRIGGER, 16'h0000);
    // Event mode counts the external pin
    acc(1, `IDX_CONVERTER_CONTROL, 16'h0041);
    acc(1, `IDX_INT_FLAG, 16'h001F);
    chk("event out", {15'h0000, evt}, 16'h0001);
    setc(`IDX_MEASURE_LOW, 24'h000000);
    setc(`IDX_TIMEBASE_LOW, 24'h000000);
    acc(1, `IDX_OSC_TRIGGER, 16'h0001);
    rdc("event run", `IDX_OSC_TRIGGER, 16'h0001);
    chk("event drive", {13'h0000, sb, sa, ra}, 16'h0000);
    repeat (5) begin
      @(posedge ref_clk) ext <= 1'b1;
      repeat (3) @(posedge ref_clk);
      ext <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
    acc(1, `IDX_OSC_TRIGGER, 16'h0000);
    rdc("event count", `IDX_MEASURE_LOW, 16'h0005);
    test_done;
  end
endmodule
bind rf_converter_ctrl rf_converter_sva i_sva (.ref_clk(ref_clk), .rst(rst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .reference_osc_drive_r(reference_osc_drive_r),
  .sensor_a_osc_drive_r(sensor_a_osc_drive_r),
  .sensor_b_osc_drive_r(sensor_b_osc_drive_r),
  .event_count_mode_out_r(event_count_mode_out_r),
  .interrupt_request_r(interrupt_request_r));
